// File: hw/spsc_pkg.sv
// Package for the serial port status and control block
package spsc_pkg;
	// Status word field positions
	localparam int STAT_RD_BUSY   = 15;
	localparam int STAT_RD_OK     = 14;
	localparam int STAT_RD_TMO    = 13;
	localparam int STAT_WR_BUSY   = 12;
	localparam int STAT_WR_OK     = 11;
	localparam int STAT_WR_TMO    = 10;
	localparam int STAT_RX_PEND   = 9;
	localparam int STAT_OVERRUN   = 8;
	localparam int STAT_FRAME     = 7;
	localparam int STAT_PARITY    = 6;
	localparam int STAT_CTS       = 5;
	localparam int STAT_DSR       = 4;
	localparam int STAT_RI        = 3;
	localparam int STAT_DCD       = 2;
	// Control word field positions
	localparam int CTRL_RTS       = 15;
	localparam int CTRL_DTR       = 14;
	// Widths
	localparam int WORD_W         = 16;
	localparam int CNT_W          = 12;
	// Receive buffer depth in characters
	localparam logic [CNT_W-1:0] BUF_DEPTH = 12'h831;
	localparam logic [CNT_W-1:0] CNT_ONE   = 12'h001;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

	// Duplex mode of the RS-485 port
	typedef enum logic [1:0] {
		SPSC_DUP_P2P   = 2'h0,
		SPSC_DUP_2WIRE = 2'h1,
		SPSC_DUP_4WIRE = 2'h2
	} spsc_duplex_t;

	// Status read answer sequencer
	typedef enum logic [1:0] {
		SPSC_ANS_IDLE  = 2'h0,
		SPSC_ANS_WORD1 = 2'h1,
		SPSC_ANS_WORD2 = 2'h3
	} spsc_ans_t;

	// Events from the transfer engines and receiver
	typedef struct packed {
		logic rd_start;
		logic rd_done;
		logic rd_timeout;
		logic rd_cancel;
		logic wr_start;
		logic wr_done;
		logic wr_timeout;
		logic wr_cancel;
		logic tx_active;
		logic rx_char;
		logic rx_take;
		logic rx_overrun;
		logic frame_err;
		logic parity_err;
	} spsc_evt_t;

	// Modem input lines
	typedef struct packed {
		logic cts;
		logic dsr;
		logic ri;
		logic dcd;
	} spsc_modem_t;

	// Whole block state
	typedef struct packed {
		logic              rd_busy;
		logic              rd_ok;
		logic              rd_tmo;
		logic              wr_busy;
		logic              wr_ok;
		logic              wr_tmo;
		logic              overrun;
		logic              frame;
		logic              parity;
		logic [CNT_W-1:0]  rx_count;
		logic              rts_cmd;
		logic              dtr_cmd;
		logic [1:0]        mdm_s1;
		logic [1:0]        mdm_s2;
		logic [1:0]        mdm_s3;
		logic [1:0]        mdm_s4;
		spsc_ans_t         ans;
		logic [WORD_W-1:0] ans_data;
		logic              ans_valid;
		logic              rts_line;
		logic              dtr_line;
		logic              drv_en;
	} spsc_state_t;
endpackage

// File: hw/spsc_core.sv
// Serial port status word, control word and RS-485 RTS gating
// Notes on behaviour
// RL1: Read busy set on read start, cleared on end
// RL2: Read success set on completion, cleared on start
// RL3: Read timeout set on timeout, cleared on start
// RL4: Write busy set on write start, cleared on end
// RL5: Write success set on completion, cleared on start
// RL6: Write timeout set on timeout, cleared on start
// RL7: Bit 9 high while characters wait
// RL8: Overrun bit sticky until status read
// RL9: Framing bit sticky until status read
// RL10: Parity bit sticky until status read
// RL11: Bit 5 follows CTS input
// RL12: Bit 4 follows DSR input
// RL13: Bit 3 ring indicator, bit 2 DCD
// RL14: Status bits 1 and 0 read zero
// RL15: Control bit 15 commands RTS; rest zero
// RL16: Control bit 14 commands DTR
// RL17: RS-485 RTS gated by transmit driver enable
// RL18: Disabled driver blocks commanded RTS on line
// RL19: 2/4-wire modes: driver enabled only while sending
// RL20: Point-to-point mode: driver always enabled
// RL21: Status read answers status then waiting count
// RL22: Full buffer discards characters, sets overrun
// RL23: Initialize cancels, flushes, drops RTS and DTR
// RL24: Read snapshots status; same-cycle error survives
`timescale 1ns/1ps
module spsc_core
	import spsc_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// Command requests from host software
	input  wire logic              status_read_req,
	input  wire logic              ctrl_write_req,
	input  wire logic [WORD_W-1:0] ctrl_write_data,
	input  wire logic              port_init_req,
	input  wire logic              is_rs485,
	input  wire spsc_duplex_t      duplex_mode,
	// Status read answer
	output logic                   ans_valid,
	output logic [WORD_W-1:0]      ans_data,
	output logic                   ans_last,
	// Engine and receiver events, same clock domain
	input  wire spsc_evt_t         evt,
	output logic                   rx_accept,
	output logic                   cancel_ops,
	output logic                   flush_buf,
	// Modem lines from the pins, asynchronous
	input  wire spsc_modem_t       modem_in,
	output logic                   rts_out,
	output logic                   dtr_out,
	output logic                   tx_drv_en
);
	spsc_state_t q;
	spsc_state_t d;
	logic        buf_full;
	logic        clr_err;
	logic [3:0]  mdm;
	logic [WORD_W-1:0] stat_word;

	// Synchronised modem lines, read only from the second stage
	assign mdm = {q.mdm_s2[1], q.mdm_s2[0], q.mdm_s4[1], q.mdm_s4[0]};
	assign buf_full = (q.rx_count == BUF_DEPTH);
	// A character is taken only when there is room for it
	assign rx_accept = evt.rx_char & ~buf_full & ~port_init_req; // RL22
	assign cancel_ops = port_init_req; // RL23
	assign flush_buf  = port_init_req; // RL23
	assign clr_err = status_read_req & (q.ans == SPSC_ANS_IDLE);

	// Live status word as it would be captured now
	always_comb begin
		stat_word = WORD_ZERO; // RL14
		stat_word[STAT_RD_BUSY] = q.rd_busy;
		stat_word[STAT_RD_OK]   = q.rd_ok;
		stat_word[STAT_RD_TMO]  = q.rd_tmo;
		stat_word[STAT_WR_BUSY] = q.wr_busy;
		stat_word[STAT_WR_OK]   = q.wr_ok;
		stat_word[STAT_WR_TMO]  = q.wr_tmo;
		stat_word[STAT_RX_PEND] = (q.rx_count != '0); // RL7
		stat_word[STAT_OVERRUN] = q.overrun;
		stat_word[STAT_FRAME]   = q.frame;
		stat_word[STAT_PARITY]  = q.parity;
		stat_word[STAT_CTS]     = mdm[3]; // RL11
		stat_word[STAT_DSR]     = mdm[2]; // RL12
		stat_word[STAT_RI]      = mdm[1]; // RL13
		stat_word[STAT_DCD]     = mdm[0]; // RL13
	end

	// Next state of the whole block
	always_comb begin
		d = q;
		// Two-stage synchronisers for the modem inputs
		d.mdm_s1 = {modem_in.cts, modem_in.dsr};
		d.mdm_s2 = q.mdm_s1;
		d.mdm_s3 = {modem_in.ri, modem_in.dcd};
		d.mdm_s4 = q.mdm_s3;

		// Read progress; a start outranks an end in the same cycle
		if (evt.rd_done | evt.rd_timeout | evt.rd_cancel | port_init_req) begin
			d.rd_busy = 1'b0; // RL1
		end
		if (evt.rd_done) begin
			d.rd_ok = 1'b1; // RL2
		end
		if (evt.rd_timeout) begin
			d.rd_tmo = 1'b1; // RL3
		end
		if (evt.rd_start & ~port_init_req) begin
			d.rd_busy = 1'b1; // RL1
			d.rd_ok   = 1'b0; // RL2
			d.rd_tmo  = 1'b0; // RL3
		end

		// Write progress
		if (evt.wr_done | evt.wr_timeout | evt.wr_cancel | port_init_req) begin
			d.wr_busy = 1'b0; // RL4
		end
		if (evt.wr_done) begin
			d.wr_ok = 1'b1; // RL5
		end
		if (evt.wr_timeout) begin
			d.wr_tmo = 1'b1; // RL6
		end
		if (evt.wr_start & ~port_init_req) begin
			d.wr_busy = 1'b1; // RL4
			d.wr_ok   = 1'b0; // RL5
			d.wr_tmo  = 1'b0; // RL6
		end

		// Waiting character count; flush on initialize
		if (port_init_req) begin
			d.rx_count = '0; // RL23
		end else if (rx_accept & ~(evt.rx_take & (q.rx_count != '0))) begin
			d.rx_count = q.rx_count + CNT_ONE; // RL7
		end else if (~rx_accept & evt.rx_take & (q.rx_count != '0)) begin
			d.rx_count = q.rx_count - CNT_ONE; // RL7
		end

		// Sticky errors: clear on status read, new error wins
		if (clr_err) begin
			d.overrun = 1'b0; // RL24
			d.frame   = 1'b0; // RL24
			d.parity  = 1'b0; // RL24
		end
		if (evt.rx_overrun | (evt.rx_char & buf_full)) begin
			d.overrun = 1'b1; // RL8 RL22
		end
		if (evt.frame_err) begin
			d.frame = 1'b1; // RL9
		end
		if (evt.parity_err) begin
			d.parity = 1'b1; // RL10
		end

		// Control word; unused bits are ignored
		if (port_init_req) begin
			d.rts_cmd = 1'b0; // RL23
			d.dtr_cmd = 1'b0; // RL23
		end else if (ctrl_write_req) begin
			d.rts_cmd = ctrl_write_data[CTRL_RTS]; // RL15
			d.dtr_cmd = ctrl_write_data[CTRL_DTR]; // RL16
		end

		// Driver enable by duplex mode
		if (duplex_mode == SPSC_DUP_P2P) begin
			d.drv_en = 1'b1; // RL20
		end else begin
			d.drv_en = evt.tx_active; // RL19
		end
		// RTS reaches the RS-485 line only through the driver
		d.rts_line = is_rs485 ? (d.rts_cmd & d.drv_en) : d.rts_cmd; // RL17 RL18
		d.dtr_line = d.dtr_cmd; // RL16

		// Two-word answer to a status read
		d.ans_valid = 1'b0;
		case (q.ans)
			SPSC_ANS_IDLE: begin
				if (status_read_req) begin
					d.ans_data  = stat_word; // RL21
					d.ans_valid = 1'b1;
					d.ans       = SPSC_ANS_WORD1;
				end
			end
			SPSC_ANS_WORD1: begin
				d.ans_data  = {{(WORD_W-CNT_W){1'b0}}, q.rx_count}; // RL21
				d.ans_valid = 1'b1;
				d.ans       = SPSC_ANS_WORD2;
			end
			SPSC_ANS_WORD2: begin
				d.ans = SPSC_ANS_IDLE;
			end
			default: begin
				d.ans = SPSC_ANS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs from flip-flops; ans_last decodes q.ans_valid and q.ans
	assign ans_valid = q.ans_valid;
	assign ans_data  = q.ans_data;
	assign ans_last  = q.ans_valid & (q.ans == SPSC_ANS_WORD2);
	assign rts_out   = q.rts_line;
	assign dtr_out   = q.dtr_line;
	assign tx_drv_en = q.drv_en;

	// Checks; the release edge is kept out where a register is still clearing
	rd_start_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
		evt.rd_start && !port_init_req |=> q.rd_busy && !q.rd_ok && !q.rd_tmo)
		else $error("read start did not set busy");
	rd_done_ok_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
		evt.rd_done && !evt.rd_start |=> q.rd_ok && !q.rd_busy)
		else $error("read done did not set success");
	rd_tmo_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL3
		evt.rd_timeout && !evt.rd_start |=> q.rd_tmo)
		else $error("read timeout not flagged");
	wr_start_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
		evt.wr_start && !port_init_req |=> q.wr_busy && !q.wr_ok && !q.wr_tmo)
		else $error("write start did not set busy");
	wr_done_ok_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL5
		evt.wr_done && !evt.wr_start |=> q.wr_ok && !q.wr_busy)
		else $error("write done did not set success");
	wr_tmo_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL6
		evt.wr_timeout && !evt.wr_start |=> q.wr_tmo)
		else $error("write timeout not flagged");
	err_survives_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
		clr_err && evt.frame_err |=> q.frame)
		else $error("frame error lost on status read");
	err_cleared_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
		clr_err && !evt.parity_err |=> !q.parity)
		else $error("parity not cleared by status read");
	full_overrun_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL22
		evt.rx_char && buf_full && !evt.rx_take && !port_init_req
		|=> q.overrun && $stable(q.rx_count))
		else $error("full buffer did not flag overrun");
	ans_two_words_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL21
		status_read_req && q.ans == SPSC_ANS_IDLE |=> ans_valid ##1 ans_valid && ans_last
		##1 !ans_valid)
		else $error("status answer not two words");
	ans_zero_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL14
		ans_valid && !ans_last |-> ans_data[STAT_DCD-1:0] == '0)
		else $error("status low bits not zero");
	rts_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL18
		is_rs485 && !tx_drv_en |-> !rts_out)
		else $error("rts driven with driver off");
	p2p_driver_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL20
		!sys_rst && duplex_mode == SPSC_DUP_P2P |=> tx_drv_en)
		else $error("driver not enabled in p2p");
	init_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL23
		port_init_req |=> !dtr_out && !rts_out && q.rx_count == '0)
		else $error("initialize did not drop lines");

	// Progress flags move only on their own events or, for busy, on initialize
	rd_end_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
		(evt.rd_cancel && !evt.rd_start) || port_init_req |=> !q.rd_busy)
		else $error("read cancel did not clear busy");
	wr_end_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
		(evt.wr_cancel && !evt.wr_start) || port_init_req |=> !q.wr_busy)
		else $error("write cancel did not clear busy");
	rd_ok_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
		!evt.rd_start && !evt.rd_done |=> $stable(q.rd_ok))
		else $error("read success moved without cause");
	wr_ok_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL5
		!evt.wr_start && !evt.wr_done |=> $stable(q.wr_ok))
		else $error("write success moved without cause");
	rd_tmo_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL3
		!evt.rd_start && !evt.rd_timeout |=> $stable(q.rd_tmo))
		else $error("read timeout moved without cause");
	wr_tmo_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL6
		!evt.wr_start && !evt.wr_timeout |=> $stable(q.wr_tmo))
		else $error("write timeout moved without cause");

	// First answer word carries the flags of the request cycle, second word the waiting count
	pend_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
		$past(clr_err) |-> ans_data[STAT_RX_PEND] == $past(q.rx_count != '0))
		else $error("pending bit does not match count");
	cts_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
		$past(clr_err) |-> ans_data[STAT_CTS] == $past(mdm[3]))
		else $error("cts bit does not follow line");
	dsr_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
		$past(clr_err) |-> ans_data[STAT_DSR] == $past(mdm[2]))
		else $error("dsr bit does not follow line");
	ri_dcd_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL13
		$past(clr_err) |-> ans_data[STAT_RI] == $past(mdm[1])
		&& ans_data[STAT_DCD] == $past(mdm[0]))
		else $error("ring or carrier bit does not follow line");
	count_word_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL21
		ans_last |-> ans_data[CNT_W-1:0] == $past(q.rx_count)
		&& ans_data[WORD_W-1:CNT_W] == '0)
		else $error("second word is not the waiting count");

	// Sticky errors: set by their event, cleared only by a taken read
	ovr_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
		evt.rx_overrun |=> q.overrun)
		else $error("overrun event not flagged");
	ovr_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
		!clr_err && q.overrun |=> q.overrun)
		else $error("overrun dropped without status read");
	frm_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
		!clr_err && q.frame |=> q.frame)
		else $error("frame error dropped without status read");
	par_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
		!clr_err && q.parity |=> q.parity)
		else $error("parity error dropped without status read");
	ovr_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
		clr_err && !evt.rx_overrun && !(evt.rx_char && buf_full) |=> !q.overrun)
		else $error("overrun not cleared by status read");
	frm_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
		clr_err && !evt.frame_err |=> !q.frame)
		else $error("frame error not cleared by status read");
	ovr_survive_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL24
		clr_err && evt.rx_overrun |=> q.overrun)
		else $error("overrun lost on status read");
	par_survive_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL24
		clr_err && evt.parity_err |=> q.parity)
		else $error("parity error lost on status read");

	// Waiting count steps by one per stored or taken character
	cnt_inc_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
		rx_accept && !evt.rx_take |=> q.rx_count == $past(q.rx_count) + CNT_ONE)
		else $error("stored character not counted");
	cnt_dec_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
		evt.rx_take && !rx_accept && !port_init_req && q.rx_count != '0
		|=> q.rx_count == $past(q.rx_count) - CNT_ONE)
		else $error("taken character not uncounted");

	// Initialize cancels transfers and flushes the receive buffer
	init_outs_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL23
		port_init_req |-> cancel_ops && flush_buf && !rx_accept)
		else $error("initialize did not cancel and flush");
	init_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL23
		port_init_req |=> !q.rd_busy && !q.wr_busy)
		else $error("initialize left an operation busy");

	// Control word and line gating
	rts_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL15
		ctrl_write_req && !port_init_req |=> q.rts_cmd == $past(ctrl_write_data[CTRL_RTS]))
		else $error("rts command not taken from control word");
	dtr_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL16
		ctrl_write_req && !port_init_req |=> dtr_out == $past(ctrl_write_data[CTRL_DTR]))
		else $error("dtr not taken from control word");
	dtr_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL16
		!ctrl_write_req && !port_init_req |=> $stable(dtr_out))
		else $error("dtr moved without a write");
	rts_plain_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL15
		!is_rs485 |=> rts_out == q.rts_cmd)
		else $error("rts does not follow command");
	rts_gated_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL17
		is_rs485 |=> rts_out == (q.rts_cmd && tx_drv_en))
		else $error("rts not gated by driver enable");
	drv_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL19
		duplex_mode != SPSC_DUP_P2P |=> tx_drv_en == $past(evt.tx_active))
		else $error("driver enable does not follow sending");
endmodule // spsc_core

// File: verification/spsc_line_model.sv
// Far-side serial device model driving the modem status lines
`timescale 1ns/1ps
module spsc_line_model
	import spsc_pkg::*;
(
	// Clock
	input  wire logic        sys_clk,
	// Line levels the bench asks for
	input  wire spsc_modem_t want,
	// Modem lines toward the port
	output spsc_modem_t      modem_in
);
	// Lines move just after an edge, unrelated to any request timing
	always_ff @(posedge sys_clk) begin
		modem_in <= want;
	end
endmodule // spsc_line_model

// File: verification/serial_port_status_control_tb.sv
// Self-checking bench for the serial port status and control block
`timescale 1ns/1ps
module serial_port_status_control_tb;
	import spsc_pkg::*;
	logic              sys_clk;
	logic              sys_rst;
	logic              status_read_req;
	logic              ctrl_write_req;
	logic [15:0]       ctrl_write_data;
	logic              port_init_req;
	logic              is_rs485;
	spsc_duplex_t      duplex_mode;
	logic              ans_valid;
	logic [15:0]       ans_data;
	logic              ans_last;
	spsc_evt_t         evt;
	logic              rx_accept;
	logic              cancel_ops;
	logic              flush_buf;
	spsc_modem_t       want;
	spsc_modem_t       modem_in;
	logic              rts_out;
	logic              dtr_out;
	logic              tx_drv_en;
	int                miscompares;
	int                check_count;
	int                cycle_cnt;

	spsc_core i_spsc_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.status_read_req(status_read_req), .ctrl_write_req(ctrl_write_req),
		.ctrl_write_data(ctrl_write_data), .port_init_req(port_init_req),
		.is_rs485(is_rs485), .duplex_mode(duplex_mode), .ans_valid(ans_valid),
		.ans_data(ans_data), .ans_last(ans_last), .evt(evt), .rx_accept(rx_accept),
		.cancel_ops(cancel_ops), .flush_buf(flush_buf), .modem_in(modem_in),
		.rts_out(rts_out), .dtr_out(dtr_out), .tx_drv_en(tx_drv_en));
	spsc_line_model i_spsc_line_model (.sys_clk(sys_clk), .want(want), .modem_in(modem_in));

	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Event bit k in declaration order of the event struct
	function automatic logic [13:0] eb(input int k);
		return 14'h2000 >> k;
	endfunction

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask

	// One-cycle event pulse
	task automatic ev(input int k);
		@(posedge sys_clk) evt <= eb(k);
		@(posedge sys_clk) evt <= '0;
	endtask

	// Status read, optional events in the request cycle, both words compared
	task automatic rs(input logic [13:0] e, input logic [15:0] es, input logic [15:0] ec);
		@(posedge sys_clk);
		status_read_req <= 1'b1;
		evt <= e;
		@(posedge sys_clk);
		status_read_req <= 1'b0;
		evt <= '0;
		#1;
		chk("status_word", es, ans_valid ? ans_data : 16'hdead);
		@(posedge sys_clk);
		#1;
		chk("count_word", ec, ans_last ? ans_data : 16'hdead);
	endtask

	task automatic wr(input logic [15:0] d);
		@(posedge sys_clk);
		ctrl_write_req <= 1'b1;
		ctrl_write_data <= d;
		@(posedge sys_clk) ctrl_write_req <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic t_modem();
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk) want <= spsc_modem_t'(4'h8 >> i);
			repeat (4) @(posedge sys_clk);
			rs('0, 16'h0020 >> i, 16'h0000);
		end
		@(posedge sys_clk) want <= '0;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_xfer();
		int          ks[12] = '{0, 1, 0, 2, 0, 3, 4, 5, 4, 6, 4, 7};
		logic [15:0] ex[12] = '{16'h8000, 16'h4000, 16'h8000, 16'h2000, 16'h8000, 16'h0000,
			16'h1000, 16'h0800, 16'h1000, 16'h0400, 16'h1000, 16'h0000};
		for (int i = 0; i < 12; i++) begin
			ev(ks[i]);
			rs('0, ex[i], 16'h0000);
		end
	endtask

	task automatic t_err();
		ev(11);
		ev(12);
		ev(13);
		rs('0, 16'h01c0, 16'h0000);
		rs(eb(12), 16'h0000, 16'h0000);
		rs('0, 16'h0080, 16'h0000);
		rs('0, 16'h0000, 16'h0000);
	endtask

	// Fill the receive buffer to the brim, then one more character
	task automatic t_rx();
		ev(9);
		ev(9);
		ev(9);
		ev(10);
		rs('0, 16'h0200, 16'h0002);
		@(posedge sys_clk) evt <= eb(9);
		#1;
		chk("rx_accept", 16'h0001, {15'h0, rx_accept});
		repeat (int'(BUF_DEPTH) - 2) @(posedge sys_clk);
		#1;
		chk("rx_accept_full", 16'h0000, {15'h0, rx_accept});
		@(posedge sys_clk) evt <= '0;
		rs('0, 16'h0300, {4'h0, BUF_DEPTH});
		@(posedge sys_clk) port_init_req <= 1'b1;
		#1;
		chk("init_outs", 16'h0003, {14'h0, cancel_ops, flush_buf});
		@(posedge sys_clk) port_init_req <= 1'b0;
		rs('0, 16'h0000, 16'h0000);
	endtask

	task automatic t_ctrl();
		wr(16'hc000);
		chk("rts_dtr", 16'h0003, {14'h0, rts_out, dtr_out});
		wr(16'h4000);
		chk("rts_dtr", 16'h0001, {14'h0, rts_out, dtr_out});
		wr(16'h8000);
		@(posedge sys_clk) is_rs485 <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("rts_drv_p2p", 16'h0003, {14'h0, rts_out, tx_drv_en});
		for (int d = 1; d < 3; d++) begin
			@(posedge sys_clk) duplex_mode <= spsc_duplex_t'(d);
			repeat (3) @(posedge sys_clk);
			#1;
			chk("rts_drv_idle", 16'h0000, {14'h0, rts_out, tx_drv_en});
			@(posedge sys_clk) evt <= eb(8);
			repeat (3) @(posedge sys_clk);
			#1;
			chk("rts_drv_send", 16'h0003, {14'h0, rts_out, tx_drv_en});
			@(posedge sys_clk) evt <= '0;
		end
		@(posedge sys_clk) port_init_req <= 1'b1;
		@(posedge sys_clk) port_init_req <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("rts_dtr_init", 16'h0000, {14'h0, rts_out, dtr_out});
	endtask

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Hang guard, the whole run needs about 2300 cycles
	always @(posedge sys_clk) begin
		cycle_cnt <= cycle_cnt + 1;
		if (cycle_cnt == 10000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		sys_rst = 1'b1;
		status_read_req = 1'b0;
		ctrl_write_req = 1'b0;
		ctrl_write_data = 16'h0000;
		port_init_req = 1'b0;
		is_rs485 = 1'b0;
		duplex_mode = SPSC_DUP_P2P;
		evt = '0;
		want = '0;
		miscompares = 0;
		check_count = 0;
		cycle_cnt = 0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_modem();
		t_xfer();
		t_err();
		t_rx();
		t_ctrl();
		end_of_test();
	end
endmodule // serial_port_status_control_tb
